// ==== design/scrb_defines.vh ====
`ifndef SCRB_DEFINES_VH
`define SCRB_DEFINES_VH

// ==========================================================
// Register indices
`define SCRB_REG_MODE 4'h0
`define SCRB_REG_STATUS 4'h1
`define SCRB_REG_TONE 4'h2
`define SCRB_REG_CLOCK 4'h3
`define SCRB_REG_SECONDS 4'h4
`define SCRB_REG_AUDIO 4'h5
`define SCRB_REG_RAMDATA 4'h6
`define SCRB_REG_RAMADDR 4'h7
`define SCRB_REG_HDR0 4'h8
`define SCRB_REG_HDR1 4'h9
`define SCRB_REG_APPSTART 4'hA
`define SCRB_REG_VOLUME 4'hB
`define SCRB_REG_APPCTL0 4'hC
`define SCRB_REG_APPCTL3 4'hF

// ==========================================================
// Serial command opcodes (8-bit instruction byte)
`define SCRB_OP_WRITE 8'h02
`define SCRB_OP_READ 8'h03

// ==========================================================
// Reset values
`define SCRB_MODE_RESET 16'h0800
`define SCRB_STATUS_RESET 16'h003C
`define SCRB_STATUS_FIRST 16'h0038
`define SCRB_STATUS_SETTLED 16'h0030
`define SCRB_ZERO_RESET 16'h0000

// ==========================================================
// Mode bit positions
`define SCRB_MB_LEFT_INVERT 0
`define SCRB_MB_ZERO_A 1
`define SCRB_MB_SOFT_RESET 2
`define SCRB_MB_ABORT 3
`define SCRB_MB_POWERDOWN 4
`define SCRB_MB_TEST 5
`define SCRB_MB_STREAM 6
`define SCRB_MB_ZERO_B 7
`define SCRB_MB_CLK_EDGE 8
`define SCRB_MB_BIT_ORDER 9
`define SCRB_MB_SHARED 10
`define SCRB_MB_NATIVE 11
`define SCRB_MB_RECORD 12
`define SCRB_MB_HIGHPASS 13
`define SCRB_MB_SOURCE 14

// ==========================================================
// Busy times in core or crystal cycles
`define SCRB_T_MODE 70
`define SCRB_T_STATUS 40
`define SCRB_T_TONE 2100
`define SCRB_T_CLOCK_XTAL 11000
`define SCRB_T_SECONDS 40
`define SCRB_T_AUDIO 3200
`define SCRB_T_RAM 80
`define SCRB_T_APPSTART 3200
`define SCRB_T_VOLUME 2100
`define SCRB_T_APPCTL 50
`define SCRB_T_SOFTRST_XTAL 16600
`define SCRB_T_SKIP_LIMIT 100
`define SCRB_SETTLE_MS 100

`endif

// ==== design/scrb_serial_control_register_bank.v ====
// Behaviour
// - Control port moves 16-bit words over SPI
// - Sixteen registers; header words read-only
// - Data-request low for per-register busy time
// - Data-request already low stays low after write
// - Soft reset busy time is 16600 crystal cycles
// - Status resets 0x3C then 0x38 then 0x30
// - Mode register resets to 0x0800
// - Mode bit 0 inverts left channel
// - Mode bit 2 soft reset, self clearing
// - Mode bit 3 aborts decode, clears header1
// - Mode bit 4 selects software powerdown
// - Data-port tests allowed only with bit 5
// - Mode bit 6 enables stream mode
// - Mode bit 8 picks data clock edge
// - Mode bit 9 selects LSb-first data bytes
// - Bit 10 shares select only with bit 11
// - Bits 12, 13 with reset start recording
// - Mode bit 14 selects recording source
// - App registers add user routine cycles
`timescale 1ns/1ps
`include "scrb_defines.vh"
`default_nettype none

module scrb_serial_control_register_bank #(
  parameter CORE_MULT = 1,
  parameter SETTLE_CYCLES = 5000000,
  parameter ABORT_CYCLES = 64
) (
  input wire mclk,
  input wire arst_n,
  input wire ctrlSelectN,
  input wire ctrlSclk,
  input wire ctrlMosi,
  output reg ctrlMiso,
  output wire ctrlMisoOeN,
  input wire decoderBusy,
  input wire appRoutineBusy,
  input wire [15:0] headerWord0In,
  input wire [15:0] headerWord1In,
  input wire headerLoad,
  output wire dataRequest,
  output reg leftInvert,
  output reg softReset,
  output reg abortDecode,
  output reg softPowerdown,
  output reg testEnable,
  output reg streamMode,
  output reg dataClockEdge,
  output reg dataBitOrder,
  output reg sharedSelect,
  output reg nativeSerialMode,
  output reg recordStart,
  output reg recordHighpass,
  output reg recordSource,
  output reg [15:0] toneEnhance,
  output reg [15:0] clockConfig,
  output reg [15:0] outputVolume
);

  // ==========================================================
  // Busy counts, cut to the 24-bit counter on purpose
  // Limitation: soft reset count times CORE_MULT must stay under 2^24
  localparam [31:0] BUSY_MODE = `SCRB_T_MODE;
  localparam [31:0] BUSY_SOFTRST = `SCRB_T_SOFTRST_XTAL * CORE_MULT;
  localparam [31:0] BUSY_STATUS = `SCRB_T_STATUS;
  localparam [31:0] BUSY_TONE = `SCRB_T_TONE;
  localparam [31:0] BUSY_CLOCK = `SCRB_T_CLOCK_XTAL * CORE_MULT;
  localparam [31:0] BUSY_SECONDS = `SCRB_T_SECONDS;
  localparam [31:0] BUSY_AUDIO = `SCRB_T_AUDIO;
  localparam [31:0] BUSY_RAM = `SCRB_T_RAM;
  localparam [31:0] BUSY_APPSTART = `SCRB_T_APPSTART;
  localparam [31:0] BUSY_VOLUME = `SCRB_T_VOLUME;
  localparam [31:0] BUSY_APPCTL = `SCRB_T_APPCTL;
  localparam [31:0] SETTLE_LAST = SETTLE_CYCLES - 1;
  localparam [31:0] ABORT_LAST = ABORT_CYCLES - 1;

  // ==========================================================
  // Busy time lookup; crystal figures scale into core cycles
  function [23:0] busyCycles;
    input [3:0] idx;
    input softRst;
    begin
      case (idx)
        `SCRB_REG_MODE: busyCycles = softRst ? BUSY_SOFTRST[23:0] : BUSY_MODE[23:0];
        `SCRB_REG_STATUS: busyCycles = BUSY_STATUS[23:0];
        `SCRB_REG_TONE: busyCycles = BUSY_TONE[23:0];
        `SCRB_REG_CLOCK: busyCycles = BUSY_CLOCK[23:0];
        `SCRB_REG_SECONDS: busyCycles = BUSY_SECONDS[23:0];
        `SCRB_REG_AUDIO: busyCycles = BUSY_AUDIO[23:0];
        `SCRB_REG_RAMDATA: busyCycles = BUSY_RAM[23:0];
        `SCRB_REG_RAMADDR: busyCycles = BUSY_RAM[23:0];
        `SCRB_REG_APPSTART: busyCycles = BUSY_APPSTART[23:0];
        `SCRB_REG_VOLUME: busyCycles = BUSY_VOLUME[23:0];
        // Header writes are dropped and cost no busy time
        `SCRB_REG_HDR0, `SCRB_REG_HDR1: busyCycles = 24'h00_0000;
        default: busyCycles = BUSY_APPCTL[23:0];
      endcase
    end
  endfunction

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  reg [1:0] selSync_q;
  reg [1:0] sclkSync_q;
  reg [1:0] mosiSync_q;
  reg sclkPrev_q;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Select resets high so no frame starts out of reset
      selSync_q <= 2'b11;
      sclkSync_q <= 2'b00;
      mosiSync_q <= 2'b00;
      sclkPrev_q <= 1'b0;
    end else begin
      selSync_q <= {selSync_q[0], ctrlSelectN};
      sclkSync_q <= {sclkSync_q[0], ctrlSclk};
      mosiSync_q <= {mosiSync_q[0], ctrlMosi};
      sclkPrev_q <= sclkSync_q[1];
    end
  end
  // Host half periods under one clock would lose edges here
  wire selActive = ~selSync_q[1];
  wire sclkRise = sclkSync_q[1] & ~sclkPrev_q;
  wire sclkFall = ~sclkSync_q[1] & sclkPrev_q;

  // ==========================================================
  // Frame: 8-bit opcode, 8-bit address, 16-bit data word
  reg [5:0] bitCnt_q;
  reg [31:0] shift_q;
  reg [15:0] readShift_q;
  reg writeStrobe_q;
  reg [3:0] wrIdx_q;
  reg [15:0] wrData_q;
  reg [15:0] readMux;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_q <= 6'd0;
      shift_q <= 32'h0000_0000;
      writeStrobe_q <= 1'b0;
      wrIdx_q <= 4'h0;
      wrData_q <= 16'h0000;
    end else begin
      writeStrobe_q <= 1'b0;
      if (!selActive) begin
        bitCnt_q <= 6'd0;
      end else if (sclkRise && bitCnt_q != 6'd32) begin
        shift_q <= {shift_q[30:0], mosiSync_q[1]};
        bitCnt_q <= bitCnt_q + 6'd1;
        // Last bit joins straight from the synchroniser, so the word lands a cycle after edge 32
        if (bitCnt_q == 6'd31 && shift_q[30:23] == `SCRB_OP_WRITE) begin
          writeStrobe_q <= 1'b1;
          wrIdx_q <= shift_q[18:15];
          wrData_q <= {shift_q[14:0], mosiSync_q[1]};
        end
      end
    end
  end

  // Read data leaves MSb first on falling edges after the address
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      readShift_q <= 16'h0000;
      ctrlMiso <= 1'b0;
    end else if (selActive && sclkFall) begin
      if (bitCnt_q == 6'd16 && shift_q[15:8] == `SCRB_OP_READ) begin
        readShift_q <= {readMux[14:0], 1'b0};
        ctrlMiso <= readMux[15];
      end else begin
        readShift_q <= {readShift_q[14:0], 1'b0};
        ctrlMiso <= readShift_q[15];
      end
    end
  end
  // Enable follows the synchronised select, two clocks behind the pin
  assign ctrlMisoOeN = ~(selActive && bitCnt_q >= 6'd16);

  // ==========================================================
  // Register storage
  reg [15:0] mode_q;
  reg [15:0] status_q;
  // Mode, status and header words live outside the array; those slots stay unused
  reg [15:0] regs_q [0:15];
  reg [15:0] header0_q;
  reg [15:0] header1_q;
  reg [1:0] statusPhase_q;
  reg [23:0] settleCnt_q;
  reg [7:0] abortCnt_q;
  integer i;
  reg [23:0] busyCnt_q;
  reg holdLow_q;
  reg appHold_q;
  wire busyDone = busyCnt_q == 24'h00_0000;
  wire appWrite = wrIdx_q == `SCRB_REG_APPSTART || wrIdx_q >= `SCRB_REG_APPCTL0;

  // ==========================================================
  // Read-back selection; the address sits in the low shift bits
  always @* begin
    case (shift_q[3:0])
      `SCRB_REG_MODE: readMux = mode_q;
      `SCRB_REG_STATUS: readMux = status_q;
      `SCRB_REG_HDR0: readMux = header0_q;
      `SCRB_REG_HDR1: readMux = header1_q;
      default: readMux = regs_q[shift_q[3:0]];
    endcase
  end

  // ==========================================================
  // Register updates
  wire wrMode = writeStrobe_q && wrIdx_q == `SCRB_REG_MODE;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `SCRB_MODE_RESET;
      status_q <= `SCRB_STATUS_RESET;
      statusPhase_q <= 2'd0;
      settleCnt_q <= 24'h00_0000;
      abortCnt_q <= 8'h00;
      header0_q <= 16'h0000;
      header1_q <= 16'h0000;
      for (i = 0; i < 16; i = i + 1)
        regs_q[i] <= `SCRB_ZERO_RESET;
    end else begin
      // Status settles: immediate step, then after the settle time
      if (statusPhase_q == 2'd0) begin
        status_q <= `SCRB_STATUS_FIRST;
        statusPhase_q <= 2'd1;
      end else if (statusPhase_q == 2'd1) begin
        if (settleCnt_q == SETTLE_LAST[23:0]) begin
          status_q <= `SCRB_STATUS_SETTLED;
          statusPhase_q <= 2'd2;
        end else begin
          settleCnt_q <= settleCnt_q + 24'd1;
        end
      end
      if (headerLoad) begin
        header0_q <= headerWord0In;
        header1_q <= headerWord1In;
      end
      // Abort stays set for ABORT_CYCLES clocks, then clears itself
      // Eight-bit counter: ABORT_CYCLES above 256 would wrap
      if (mode_q[`SCRB_MB_ABORT]) begin
        header1_q <= 16'h0000;
        if (abortCnt_q == ABORT_LAST[7:0]) begin
          mode_q[`SCRB_MB_ABORT] <= 1'b0;
          abortCnt_q <= 8'h00;
        end else begin
          abortCnt_q <= abortCnt_q + 8'h01;
        end
      end
      // Soft reset bit clears itself once the busy time ends
      if (mode_q[`SCRB_MB_SOFT_RESET] && busyDone)
        mode_q[`SCRB_MB_SOFT_RESET] <= 1'b0;
      if (writeStrobe_q) begin
        case (wrIdx_q)
          `SCRB_REG_MODE: begin
            mode_q <= wrData_q;
            abortCnt_q <= 8'h00;
          end
          `SCRB_REG_STATUS: status_q <= wrData_q;
          `SCRB_REG_HDR0, `SCRB_REG_HDR1: ;
          default: regs_q[wrIdx_q] <= wrData_q;
        endcase
      end
    end
  end

  // ==========================================================
  // Data-request busy counter
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busyCnt_q <= 24'h00_0000;
      holdLow_q <= 1'b0;
      appHold_q <= 1'b0;
    end else begin
      if (writeStrobe_q) begin
        busyCnt_q <= busyCycles(wrIdx_q, wrData_q[`SCRB_MB_SOFT_RESET]);
        // A write that finds the line low keeps it low past its own busy time
        holdLow_q <= ~dataRequest;
        appHold_q <= appWrite;
      end else begin
        if (!busyDone)
          busyCnt_q <= busyCnt_q - 24'd1;
        if (busyDone && !appRoutineBusy)
          appHold_q <= 1'b0;
        if (busyDone && !decoderBusy)
          holdLow_q <= 1'b0;
      end
    end
  end
  // Writes under the skip limit, header writes aside, still drive the line low briefly
  // Held low until the soft reset field drops, so ready never precedes the restart
  assign dataRequest = busyDone && !holdLow_q && !appHold_q && !decoderBusy && !softReset;

  // ==========================================================
  // Mode fields out to the decoder
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      leftInvert <= 1'b0;
      softReset <= 1'b0;
      abortDecode <= 1'b0;
      softPowerdown <= 1'b0;
      testEnable <= 1'b0;
      streamMode <= 1'b0;
      dataClockEdge <= 1'b0;
      dataBitOrder <= 1'b0;
      sharedSelect <= 1'b0;
      nativeSerialMode <= 1'b1;
      recordStart <= 1'b0;
      recordHighpass <= 1'b0;
      recordSource <= 1'b0;
      toneEnhance <= 16'h0000;
      clockConfig <= 16'h0000;
      outputVolume <= 16'h0000;
    end else begin
      leftInvert <= mode_q[`SCRB_MB_LEFT_INVERT];
      softReset <= mode_q[`SCRB_MB_SOFT_RESET];
      abortDecode <= mode_q[`SCRB_MB_ABORT];
      softPowerdown <= mode_q[`SCRB_MB_POWERDOWN];
      testEnable <= mode_q[`SCRB_MB_TEST];
      streamMode <= mode_q[`SCRB_MB_STREAM];
      dataClockEdge <= mode_q[`SCRB_MB_CLK_EDGE];
      dataBitOrder <= mode_q[`SCRB_MB_BIT_ORDER];
      sharedSelect <= mode_q[`SCRB_MB_SHARED] & mode_q[`SCRB_MB_NATIVE];
      nativeSerialMode <= mode_q[`SCRB_MB_NATIVE];
      // Record flags latch only on a write that also asks for soft reset
      if (wrMode && wrData_q[`SCRB_MB_SOFT_RESET]) begin
        recordStart <= wrData_q[`SCRB_MB_RECORD];
        recordHighpass <= wrData_q[`SCRB_MB_RECORD] & wrData_q[`SCRB_MB_HIGHPASS];
      end
      recordSource <= mode_q[`SCRB_MB_SOURCE];
      toneEnhance <= regs_q[`SCRB_REG_TONE];
      clockConfig <= regs_q[`SCRB_REG_CLOCK];
      outputVolume <= regs_q[`SCRB_REG_VOLUME];
    end
  end

endmodule
`default_nettype wire

// ==== sim/scrb_bank_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checker
module scrb_bank_props #(
  parameter CORE_MULT = 1,
  parameter SETTLE_CYCLES = 5000000,
  parameter ABORT_CYCLES = 64
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ctrlSelectN,
  input wire logic ctrlMisoOeN,
  input wire logic decoderBusy,
  input wire logic dataRequest,
  input wire logic softReset,
  input wire logic abortDecode,
  input wire logic dataClockEdge,
  input wire logic sharedSelect,
  input wire logic nativeSerialMode,
  input wire logic recordStart,
  input wire logic [15:0] toneEnhance,
  input wire logic [15:0] clockConfig,
  input wire logic [15:0] outputVolume
);
  logic [31:0] rstCnt_q;
  // Soft reset outlasts any delay range, so it is counted
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rstCnt_q <= 32'h0000_0000;
    else rstCnt_q <= softReset ? rstCnt_q + 32'h0000_0001 : 32'h0000_0000;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_modeUpd; $changed(dataClockEdge) && !decoderBusy && !softReset; endsequence
  sequence s_backSoon; ##[1:80] dataRequest; endsequence
  property p_modeBusy; s_modeUpd |-> s_backSoon; endproperty
  a_modeBusy: assert property (p_modeBusy) else $error("mode busy too long");
  property p_volBusy; $changed(outputVolume) |=> (!dataRequest)[*8]; endproperty
  a_volBusy: assert property (p_volBusy) else $error("volume busy short");
  property p_toneClk; $changed(toneEnhance) || $changed(clockConfig) |=> (!dataRequest)[*8]; endproperty
  a_toneClk: assert property (p_toneClk) else $error("tone or clock busy short");
  property p_decBusy; decoderBusy[*3] |-> !dataRequest; endproperty
  a_decBusy: assert property (p_decBusy) else $error("ready while decoder busy");
  property p_rstLow; softReset[*2] |-> !dataRequest; endproperty
  a_rstLow: assert property (p_rstLow) else $error("ready during soft reset");
  property p_rstLen; rstCnt_q <= 16600 * CORE_MULT + 100; endproperty
  a_rstLen: assert property (p_rstLen) else $error("soft reset never clears");
  property p_abort; $rose(abortDecode) |-> ##[1:100] !abortDecode; endproperty
  a_abort: assert property (p_abort) else $error("abort never clears");
  property p_record; $rose(recordStart) |=> softReset; endproperty
  a_record: assert property (p_record) else $error("record without reset");
  property p_shared; sharedSelect |-> nativeSerialMode; endproperty
  a_shared: assert property (p_shared) else $error("shared select without native");
  property p_selIdle; ctrlSelectN[*4] |-> ctrlMisoOeN; endproperty
  a_selIdle: assert property (p_selIdle) else $error("read data driven unselected");
endmodule
bind scrb_serial_control_register_bank scrb_bank_props #(.CORE_MULT(CORE_MULT),
  .SETTLE_CYCLES(SETTLE_CYCLES), .ABORT_CYCLES(ABORT_CYCLES)) u_scrb_bank_props (.mclk(mclk),
  .arst_n(arst_n), .ctrlSelectN(ctrlSelectN), .ctrlMisoOeN(ctrlMisoOeN), .decoderBusy(decoderBusy),
  .dataRequest(dataRequest), .softReset(softReset), .abortDecode(abortDecode),
  .dataClockEdge(dataClockEdge), .sharedSelect(sharedSelect), .nativeSerialMode(nativeSerialMode),
  .recordStart(recordStart), .toneEnhance(toneEnhance), .clockConfig(clockConfig),
  .outputVolume(outputVolume));
`default_nettype wire

// ==== sim/scrb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========
// Host serial master
module scrb_host_model (
  input wire logic mclk,
  output logic selN,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  input wire logic misoOeN
);
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b1;
  end
  // Half period of 6 mclk leaves room for the pin synchronisers
  task automatic xfer(input logic [7:0] op, input logic [3:0] adr, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [31:0] sh;
    sh = {op, 4'h0, adr, wd};
    rd = 16'h0000;
    @(negedge mclk) selN = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      repeat (6) @(negedge mclk);
      sclk = 1'b0;
      mosi = sh[i];
      repeat (6) @(negedge mclk);
      if (i < 16) rd = {rd[14:0], miso & ~misoOeN};
      sclk = 1'b1;
    end
    repeat (6) @(negedge mclk);
    sclk = 1'b0;
    mosi = ~mosi;
    repeat (6) @(negedge mclk);
    selN = 1'b1;
    // Even spacing between short four-byte frames; select stays high long enough to be seen
    repeat (6) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ==== sim/scrb_serial_control_register_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench
module scrb_serial_control_register_bank_tb;
  logic mclk, arst_n, selN, sclk, mosi, miso, misoOeN, decBusy, appBusy, hdrLoad, data_request;
  logic leftInv, softRst, abortDec, pdown, tests, stream, dEdge, bOrder, shared, native;
  logic recStart, recHp, recSrc;
  logic [15:0] hdr0, hdr1, rdv, tone, clkCfg, output_volume;
  int miscompares = 0;
  int checked = 0;
  scrb_host_model u_scrb_host_model (.mclk(mclk), .selN(selN), .sclk(sclk), .mosi(mosi), .miso(miso),
    .misoOeN(misoOeN));
  scrb_serial_control_register_bank #(.SETTLE_CYCLES(100)) u_scrb_serial_control_register_bank (
    .mclk(mclk), .arst_n(arst_n), .ctrlSelectN(selN), .ctrlSclk(sclk), .ctrlMosi(mosi), .ctrlMiso(miso),
    .ctrlMisoOeN(misoOeN), .decoderBusy(decBusy), .appRoutineBusy(appBusy), .headerWord0In(hdr0),
    .headerWord1In(hdr1), .headerLoad(hdrLoad), .dataRequest(data_request), .leftInvert(leftInv),
    .softReset(softRst), .abortDecode(abortDec), .softPowerdown(pdown), .testEnable(tests),
    .streamMode(stream), .dataClockEdge(dEdge), .dataBitOrder(bOrder), .sharedSelect(shared),
    .nativeSerialMode(native), .recordStart(recStart), .recordHighpass(recHp), .recordSource(recSrc),
    .toneEnhance(tone), .clockConfig(clkCfg), .outputVolume(output_volume));
  always #10 mclk = ~mclk;
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] ign;
    u_scrb_host_model.xfer(8'h02, a, d, ign);
  endtask
  task automatic rd(input logic [3:0] a);
    u_scrb_host_model.xfer(8'h03, a, 16'h0000, rdv);
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    while (data_request !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    chk("ready", 16'h0001, {15'h0000, data_request});
  endtask
  task automatic t_resetVals();
    logic [15:0] rv [16] = '{0: 16'h0800, 1: 16'h0030, default: 16'h0000};
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0]);
      chk("reset value", rv[i], rdv);
    end
  endtask
  task automatic t_modes();
    logic [15:0] mv [9] = '{16'h0801, 16'h0810, 16'h0820, 16'h0840, 16'h0900, 16'h0A00, 16'h0C00,
      16'h0400, 16'h4800};
    for (int i = 0; i < 9; i++) begin
      wr(4'h0, mv[i]);
      chk("mode fields", {7'h00, mv[i][14], mv[i][11], mv[i][10] & mv[i][11], mv[i][9:8], mv[i][6:4],
        mv[i][0]}, {7'h00, recSrc, native, shared, bOrder, dEdge, stream, tests, pdown, leftInv});
      rd(4'h0);
      chk("mode readback", mv[i], rdv);
    end
  endtask
  task automatic t_softReset();
    wr(4'h0, 16'h3804);
    chk("record start", 16'h0003, {13'h0000, data_request, recStart, recHp});
    waitRdy();
    rd(4'h0);
    chk("reset bit", 16'h0000, rdv & 16'h0004);
  endtask
  task automatic t_headers();
    hdr0 = 16'h1234;
    hdr1 = 16'h5678;
    hdrLoad = 1'b1;
    @(negedge mclk) hdrLoad = 1'b0;
    wr(4'h8, 16'hFFFF);
    rd(4'h8);
    chk("header 0", 16'h1234, rdv);
    wr(4'h0, 16'h0808);
    rd(4'h9);
    chk("header 1", 16'h0000, rdv);
    rd(4'h0);
    chk("abort bit", 16'h0000, rdv & 16'h0008);
  endtask
  task automatic t_busy();
    decBusy = 1'b1;
    wr(4'hB, 16'h2020);
    repeat (2200) @(negedge mclk);
    chk("held low", 16'h0000, {15'h0000, data_request});
    chk("volume", 16'h2020, output_volume);
    decBusy = 1'b0;
    waitRdy();
    appBusy = 1'b1;
    wr(4'hC, 16'h0001);
    repeat (200) @(negedge mclk);
    chk("app busy", 16'h0000, {15'h0000, data_request});
    appBusy = 1'b0;
    waitRdy();
    wr(4'h2, 16'h00F6);
    waitRdy();
    chk("tone", 16'h00F6, tone);
    wr(4'h3, 16'h9BE8);
    waitRdy();
    chk("clock", 16'h9BE8, clkCfg);
  endtask
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    {decBusy, appBusy, hdrLoad} = 3'h0;
    {hdr0, hdr1} = 32'h0000_0000;
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    t_resetVals();
    t_modes();
    t_softReset();
    t_headers();
    t_busy();
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
